// ===== dasfc_ctrl.sv
// frame-level serial interface of the dual 16-bit converter
//
// Summary of operation
// - A frame runs from frame-select fall to its next rise; data timed by sclk.
// - Enough edges: the frame's write updates registers at frame-select rise.
// - Too few edges: the write is dropped and registers stay unchanged.
// - Long frames convert internally within 16 sclk periods, data follows.
// - 16-bit member offers long frames only; short frames need lower resolution.
// - Long single mode: both results on primary output, secondary stays off.
// - Frame start enables primary output driving 0 during conversion.
// - Single mode: A's MSB on 16th falling edge, then rest of A, then B.
// - After conversion the sample-and-hold returns to sampling.
// - Frame-select rise ends the frame and releases both outputs.
// - Results are 16-bit two's complement, saturating at 8000 and 7FFF.
// - Config words are 16 bits: top nibble command, rest is payload.
`timescale 1ns/1ps
module dasfc_ctrl
  import dasfc_pkg::*;
(
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  input  wire logic          i_frame_select_n,
  input  wire logic          i_sclk,
  input  wire logic          i_sdi,
  input  wire dasfc_sample_t i_sample,
  input  wire logic          i_sample_valid,
  output logic               o_sample_ready,
  output logic               o_primary_serial_out,
  output logic               o_primary_serial_out_oe,
  output logic               o_secondary_serial_out,
  output logic               o_secondary_serial_out_oe,
  output logic               o_sampling,
  output logic [15:0]        o_reference_level_a,
  output logic [15:0]        o_reference_level_b,
  output logic [15:0]        o_configuration_word
);

  function automatic logic [15:0] saturate(logic signed [RAW_BITS-1:0] v);
    if (v > RAW_POS_MAX) begin
      return RES_POS_FULL;
    end else if (v < RAW_NEG_MIN) begin
      return RES_NEG_FULL;
    end
    return v[15:0];
  endfunction : saturate

  // pins: frame select, clock, data in
  logic [2:0]          pins_s;
  logic                fs_n_s;
  logic                sclk_s;
  logic                sdi_s;
  logic                fs_n_prev_ff;
  logic                sclk_prev_ff;
  logic                in_frame_ff;
  logic [5:0]          edges_ff;
  logic [5:0]          nxt_edges;
  logic [15:0]         shift_in_ff;
  dasfc_result_t       res_ff;
  dasfc_result_t       cur_res;
  dasfc_sample_t       fifo_data;
  logic                fifo_valid;
  logic                frame_start;

  dasfc_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clock       (i_clock),
    .i_rst         (i_rst),
    .i_async       ({i_frame_select_n, i_sclk, i_sdi}),
    .i_reset_value (3'h6),
    .o_sync        (pins_s)
  );

  assign fs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  dasfc_fifo #(
    .WIDTH ($bits(dasfc_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_data  (i_sample),
    .i_valid (i_sample_valid),
    .o_ready (o_sample_ready),
    .o_data  (fifo_data),
    .o_valid (fifo_valid),
    .i_ready (frame_start)
  );

  // frame events
  assign frame_start = fs_n_prev_ff & ~fs_n_s;
  wire frame_end   = ~fs_n_prev_ff & fs_n_s & in_frame_ff;
  wire sclk_fall   = sclk_prev_ff & ~sclk_s & in_frame_ff & ~fs_n_s;

  // mode decode from the live configuration
  wire single_mode = o_configuration_word[CFG_SINGLE_BIT];
  wire short_mode  = o_configuration_word[CFG_SHORT_BIT]
                     & SHORT_FRAME_SUPPORTED;
  wire [5:0] need_edges = short_mode
                          ? (single_mode ? EDGES_SHORT_SINGLE
                                         : EDGES_SHORT_DUAL)
                          : (single_mode ? EDGES_LONG_SINGLE
                                         : EDGES_LONG_DUAL);
  wire [5:0] data_start = short_mode ? SHORT_DATA_START : CONV_EDGES;

  assign nxt_edges = (edges_ff == EDGES_MAX) ? edges_ff : edges_ff + 6'h01;

  // short frames shift old data from the frame's first instant
  wire [5:0] bit_edge = frame_start ? 6'h00 : nxt_edges;
  wire [5:0] pos      = bit_edge - data_start;
  wire       in_data  = (bit_edge >= data_start);

  // freshly popped sample is used in the very cycle it is latched
  assign cur_res.res_a = (frame_start & fifo_valid)
                         ? saturate(fifo_data.raw_a) : res_ff.res_a;
  assign cur_res.res_b = (frame_start & fifo_valid)
                         ? saturate(fifo_data.raw_b) : res_ff.res_b;

  // 15 - pos equals ~pos over four bits
  wire bit_a = cur_res.res_a[~pos[3:0]];
  wire bit_b = cur_res.res_b[~pos[3:0]];
  wire nxt_primary = in_data & ((pos < 6'h10) ? bit_a
                     : (single_mode & (pos < 6'h20)) ? bit_b
                     : 1'b0);
  wire nxt_secondary = in_data & (pos < 6'h10) & bit_b;

  // write validation and decode
  wire        write_ok = frame_end & (edges_ff >= need_edges);
  wire [3:0]  cmd      = shift_in_ff[CMD_MSB:CMD_LSB];
  wire [15:0] payload  = {4'h0, shift_in_ff[PAYLOAD_MSB:0]};
  wire        wr_cfg   = write_ok & (cmd == CMD_WR_CFG);
  wire        wr_ref_a = write_ok & (cmd == CMD_WR_REF_A);
  wire        wr_ref_b = write_ok & (cmd == CMD_WR_REF_B);
  wire        conv_done = sclk_fall & ~short_mode & (nxt_edges == CONV_EDGES);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fs_n_prev_ff <= 1'b1;
      sclk_prev_ff <= 1'b1;
    end else begin
      fs_n_prev_ff <= fs_n_s;
      sclk_prev_ff <= sclk_s;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      in_frame_ff <= 1'b0;
      edges_ff    <= '0;
      shift_in_ff <= '0;
    end else if (frame_start) begin
      in_frame_ff <= 1'b1;
      edges_ff    <= '0;
      shift_in_ff <= '0;
    end else if (frame_end) begin
      in_frame_ff <= 1'b0;
    end else if (sclk_fall) begin
      edges_ff <= nxt_edges;
      if (edges_ff < 6'h10) begin
        shift_in_ff <= {shift_in_ff[14:0], sdi_s};
      end
    end
  end

  // previous result repeats if the front end has nothing new
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      res_ff <= '0;
    end else if (frame_start) begin
      res_ff <= cur_res;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sampling <= 1'b1;
    end else if (frame_start) begin
      o_sampling <= 1'b0;
    end else if (conv_done | frame_end) begin
      o_sampling <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_primary_serial_out      <= 1'b0;
      o_primary_serial_out_oe   <= 1'b0;
      o_secondary_serial_out    <= 1'b0;
      o_secondary_serial_out_oe <= 1'b0;
    end else if (frame_start | sclk_fall) begin
      o_primary_serial_out      <= nxt_primary;
      o_primary_serial_out_oe   <= 1'b1;
      o_secondary_serial_out    <= ~single_mode & nxt_secondary;
      o_secondary_serial_out_oe <= ~single_mode;
    end else if (frame_end) begin
      o_primary_serial_out      <= 1'b0;
      o_primary_serial_out_oe   <= 1'b0;
      o_secondary_serial_out    <= 1'b0;
      o_secondary_serial_out_oe <= 1'b0;
    end
  end

  // registers change only when the frame closes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_configuration_word <= CFG_RESET;
      o_reference_level_a  <= REF_RESET;
      o_reference_level_b  <= REF_RESET;
    end else begin
      if (wr_cfg) begin
        o_configuration_word <= payload;
      end
      if (wr_ref_a) begin
        o_reference_level_a <= payload;
      end
      if (wr_ref_b) begin
        o_reference_level_b <= payload;
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_start_drives_zero;
    frame_start & ~short_mode |=> o_primary_serial_out_oe
                                  && !o_primary_serial_out;
  endproperty
  a_start_drives_zero: assert property (p_start_drives_zero)
    else $error("primary output not driving 0 at frame start");

  property p_end_releases;
    frame_end |=> !o_primary_serial_out_oe && !o_secondary_serial_out_oe;
  endproperty
  a_end_releases: assert property (p_end_releases)
    else $error("outputs still enabled after frame end");

  property p_single_secondary_off;
    single_mode |=> !o_secondary_serial_out_oe;
  endproperty
  a_single_secondary_off: assert property (p_single_secondary_off)
    else $error("secondary output enabled in single mode");

  property p_write_taken;
    frame_end && edges_ff >= need_edges && cmd == CMD_WR_CFG
      |=> o_configuration_word == {4'h0, $past(shift_in_ff[11:0])};
  endproperty
  a_write_taken: assert property (p_write_taken)
    else $error("valid configuration write not applied");

  property p_write_dropped;
    frame_end && edges_ff < need_edges
      |=> $stable(o_configuration_word) && $stable(o_reference_level_a)
          && $stable(o_reference_level_b);
  endproperty
  a_write_dropped: assert property (p_write_dropped)
    else $error("short frame changed a register");

  property p_msb_on_16th;
    sclk_fall && single_mode && !short_mode && edges_ff == 6'h0F
      |=> o_primary_serial_out == res_ff.res_a[15];
  endproperty
  a_msb_on_16th: assert property (p_msb_on_16th)
    else $error("converter A MSB not on 16th falling edge");

  property p_b_msb_on_32nd;
    sclk_fall && single_mode && !short_mode && edges_ff == 6'h1F
      |=> o_primary_serial_out == res_ff.res_b[15];
  endproperty
  a_b_msb_on_32nd: assert property (p_b_msb_on_32nd)
    else $error("converter B MSB not on 32nd falling edge");

  property p_sampling_after_conv;
    sclk_fall && !short_mode && edges_ff == 6'h0F |=> o_sampling;
  endproperty
  a_sampling_after_conv: assert property (p_sampling_after_conv)
    else $error("sample-and-hold not back to sampling");

  property p_hold_during_conv;
    frame_start |=> !o_sampling;
  endproperty
  a_hold_during_conv: assert property (p_hold_during_conv)
    else $error("no hold at frame start");

  property p_saturate_pos;
    frame_start && fifo_valid && fifo_data.raw_a > RAW_POS_MAX
      |=> res_ff.res_a == 16'h7FFF;
  endproperty
  a_saturate_pos: assert property (p_saturate_pos)
    else $error("positive overrange not saturated");

  property p_saturate_neg;
    frame_start && fifo_valid && fifo_data.raw_b < RAW_NEG_MIN
      |=> res_ff.res_b == 16'h8000;
  endproperty
  a_saturate_neg: assert property (p_saturate_neg)
    else $error("negative overrange not saturated");

  // short bit set or not, the first 15 falls still carry no data
  property p_long_only;
    sclk_fall && edges_ff < 6'h0F |=> !o_primary_serial_out;
  endproperty
  a_long_only: assert property (p_long_only)
    else $error("data shifted inside the long-frame conversion time");

  property p_frame_bounds;
    frame_start |=> in_frame_ff && edges_ff == 6'h00;
  endproperty
  a_frame_bounds: assert property (p_frame_bounds)
    else $error("frame did not open on frame-select fall");

  property p_bad_cmd_ignored;
    frame_end && cmd[3] == 1'b0 |=> $stable(o_configuration_word);
  endproperty
  a_bad_cmd_ignored: assert property (p_bad_cmd_ignored)
    else $error("non-write command changed configuration");

  c_valid_write: cover property (wr_cfg);
  c_dropped_write: cover property (frame_end && edges_ff < need_edges);
  c_single_frame: cover property (frame_end && single_mode
                                  && edges_ff >= EDGES_LONG_SINGLE);
  c_fifo_full: cover property (!o_sample_ready);

endmodule : dasfc_ctrl

// ===== dasfc_pkg.sv
// constants and carrier types for the dual converter serial frame block
package dasfc_pkg;

  localparam int          RESULT_BITS  = 16;
  localparam int          RAW_BITS     = 18;
  localparam int          EDGE_BITS    = 6;
  localparam int          FIFO_DEPTH   = 4;

  // falling edges needed per frame, per mode
  localparam logic [5:0]  EDGES_LONG_DUAL    = 6'h20;
  localparam logic [5:0]  EDGES_LONG_SINGLE  = 6'h30;
  localparam logic [5:0]  EDGES_SHORT_DUAL   = 6'h10;
  localparam logic [5:0]  EDGES_SHORT_SINGLE = 6'h20;
  localparam logic [5:0]  EDGES_MAX          = 6'h3F;
  // conversion occupies the first 16 serial clock periods
  localparam logic [5:0]  CONV_EDGES         = 6'h10;
  localparam logic [5:0]  SHORT_DATA_START   = 6'h00;

  // only the 16-bit member exists here: short frames are not offered
  localparam logic        SHORT_FRAME_SUPPORTED = 1'b0;

  // configuration word layout
  localparam int          CMD_MSB        = 15;
  localparam int          CMD_LSB        = 12;
  localparam int          PAYLOAD_MSB    = 11;
  localparam int          CFG_SHORT_BIT  = 11;
  localparam int          CFG_SINGLE_BIT = 10;
  localparam logic [3:0]  CMD_WR_CFG     = 4'h8;
  localparam logic [3:0]  CMD_WR_REF_A   = 4'h9;
  localparam logic [3:0]  CMD_WR_REF_B   = 4'hA;

  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [15:0] REF_RESET      = 16'h0000;

  // saturation limits of the two's-complement result
  localparam logic signed [17:0] RAW_POS_MAX = 18'sh07FFF;
  localparam logic signed [17:0] RAW_NEG_MIN = 18'sh38000;
  localparam logic [15:0] RES_POS_FULL   = 16'h7FFF;
  localparam logic [15:0] RES_NEG_FULL   = 16'h8000;

  typedef struct packed {
    logic signed [RAW_BITS-1:0] raw_a;
    logic signed [RAW_BITS-1:0] raw_b;
  } dasfc_sample_t;

  typedef struct packed {
    logic [RESULT_BITS-1:0] res_a;
    logic [RESULT_BITS-1:0] res_b;
  } dasfc_result_t;

endpackage : dasfc_pkg

// ===== dasfc_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dasfc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_reset_value,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;

  // reset value is a constant at every instance
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_ff <= i_reset_value;
      o_sync  <= i_reset_value;
    end else begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end
endmodule : dasfc_sync

// ===== dasfc_fifo.sv
// small sample fifo with valid/ready on both sides
`timescale 1ns/1ps
module dasfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      count_ff;
  logic [PW:0]      nxt_count;

  wire push = i_valid & o_ready;
  wire pop  = o_valid & i_ready;

  assign o_valid   = (count_ff != '0);
  assign o_data    = mem_ff[rd_ptr_ff];
  assign nxt_count = count_ff + (PW+1)'(push) - (PW+1)'(pop);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      o_ready   <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      o_ready  <= (nxt_count != FULL_COUNT);
    end
  end
endmodule : dasfc_fifo

// ===== dasfc_host_model.sv
// host-side serial master model that runs converter frames
`timescale 1ns/1ps
module dasfc_host_model (
  input  wire logic i_clock,
  input  wire logic i_primary,
  input  wire logic i_primary_oe,
  input  wire logic i_secondary,
  input  wire logic i_secondary_oe,
  input  wire logic i_sampling,
  output logic      o_frame_select_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  logic [63:0] rx_p;
  logic [63:0] rx_s;
  logic [63:0] oe_p;
  logic [63:0] oe_s;
  logic [63:0] samp;
  int          hold_delay;

  // sclk parks high between frames, edges only inside a frame
  initial begin
    o_frame_select_n = 1'b1;
    o_sclk           = 1'b1;
    o_sdi            = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick

  // 80 ns sclk; bits taken 70 ns after each fall, before the next
  // caller enters just after a clock edge
  task automatic frame(input logic [15:0] word, input int n_falls);
    rx_p = '0;
    rx_s = '0;
    oe_p = '0;
    oe_s = '0;
    samp = '0;
    hold_delay       = 0;
    o_frame_select_n = 1'b0;
    o_sdi            = word[15];
    // position latched here; the hold must follow within four clocks
    for (int c = 1; c <= 4; c++) begin
      tick(1);
      if (!i_sampling && hold_delay == 0)
        hold_delay = c;
    end
    for (int k = 1; k <= n_falls; k++) begin
      o_sclk = 1'b0;
      tick(4);
      o_sclk = 1'b1;
      // past the word sdi keeps moving so a stale bit cannot pass
      o_sdi  = (k < 16) ? word[15-k] : ~o_sdi;
      tick(3);
      // a released line reads inverted so a missing drive shows up
      rx_p[k] = i_primary_oe ? i_primary : ~i_primary;
      rx_s[k] = i_secondary_oe ? i_secondary : ~i_secondary;
      oe_p[k] = i_primary_oe;
      oe_s[k] = i_secondary_oe;
      samp[k] = i_sampling;
      tick(1);
    end
    tick(3);
    o_frame_select_n = 1'b1;
    o_sdi            = ~o_sdi;
    // one call per periodic timer event, period shortened
    tick(8);
  endtask : frame
endmodule : dasfc_host_model

// ===== dasfc_ctrl_tb_top.sv
// self-checking bench for the dual converter serial frame block
`timescale 1ns/1ps
module dasfc_ctrl_tb_top;
  import dasfc_pkg::*;

  logic          i_clock;
  logic          i_rst;
  logic          fs_n;
  logic          sclk;
  logic          sdi;
  dasfc_sample_t sample;
  logic          sample_valid;
  logic          sample_ready;
  logic          p_out;
  logic          p_oe;
  logic          s_out;
  logic          s_oe;
  logic          sampling;
  logic [15:0]   ref_a;
  logic [15:0]   ref_b;
  logic [15:0]   cfg;
  int            n_fail;
  int            comparisons;
  wire  [63:0]   rx_p = i_dasfc_host_model.rx_p;
  wire  [63:0]   rx_s = i_dasfc_host_model.rx_s;
  wire  [63:0]   oe_p = i_dasfc_host_model.oe_p;
  wire  [63:0]   oe_s = i_dasfc_host_model.oe_s;
  wire  [63:0]   samp = i_dasfc_host_model.samp;

  // out-of-range, zero, minus one and exact limit inputs
  logic [17:0] tab_a [4] = '{18'h10000, 18'h00000, 18'h07FFF, 18'h3FFFE};
  logic [17:0] tab_b [4] = '{18'h30000, 18'h3FFFF, 18'h38000, 18'h00001};
  logic [15:0] exp_a [4] = '{16'h7FFF, 16'h0000, 16'h7FFF, 16'hFFFE};
  logic [15:0] exp_b [4] = '{16'h8000, 16'hFFFF, 16'h8000, 16'h0001};

  dasfc_ctrl i_dasfc_ctrl (
    .i_clock                   (i_clock),
    .i_rst                     (i_rst),
    .i_frame_select_n          (fs_n),
    .i_sclk                    (sclk),
    .i_sdi                     (sdi),
    .i_sample                  (sample),
    .i_sample_valid            (sample_valid),
    .o_sample_ready            (sample_ready),
    .o_primary_serial_out      (p_out),
    .o_primary_serial_out_oe   (p_oe),
    .o_secondary_serial_out    (s_out),
    .o_secondary_serial_out_oe (s_oe),
    .o_sampling                (sampling),
    .o_reference_level_a       (ref_a),
    .o_reference_level_b       (ref_b),
    .o_configuration_word      (cfg)
  );

  dasfc_host_model i_dasfc_host_model (
    .i_clock          (i_clock),
    .i_primary        (p_out),
    .i_primary_oe     (p_oe),
    .i_secondary      (s_out),
    .i_secondary_oe   (s_oe),
    .i_sampling       (sampling),
    .o_frame_select_n (fs_n),
    .o_sclk           (sclk),
    .o_sdi            (sdi)
  );

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick

  task automatic test_done;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // 16 captured bits, msb at position first
  function automatic logic [15:0] field(input logic [63:0] v,
                                        input int first);
    logic [15:0] r;
    for (int i = 0; i < 16; i++)
      r[15-i] = v[first+i];
    return r;
  endfunction : field

  // ends with a spare cycle so valid never toggles twice in one step
  task automatic push(input logic [17:0] a, input logic [17:0] b);
    sample.raw_a = a;
    sample.raw_b = b;
    sample_valid = 1'b1;
    tick(1);
    sample_valid = 1'b0;
    tick(1);
  endtask : push

  // one frame plus what every long frame must show
  task automatic run(input logic [15:0] word, input int n);
    i_dasfc_host_model.frame(word, n);
    check(16'(rx_p[15:1]), 16'h0000);
    check(16'(oe_p[15:1]), 16'h7FFF);
    check({14'h0, samp[15], samp[16]}, 16'h0001);
    check({14'h0, p_oe, s_oe}, 16'h0000);
    check({15'h0, sampling}, 16'h0001);
    check(16'(i_dasfc_host_model.hold_delay >= 1
              && i_dasfc_host_model.hold_delay <= 4), 16'h0001);
  endtask : run

  task automatic t_reset;
    check(ref_a, REF_RESET);
    check(ref_b, REF_RESET);
    check(cfg, CFG_RESET);
    check({14'h0, p_oe, s_oe}, 16'h0000);
    check({15'h0, sample_ready}, 16'h0001);
  endtask : t_reset

  // default long dual mode, 32 falls suffice
  task automatic t_dual;
    push(18'h01234, 18'h3FFFE);
    run(16'h9FF8, 32);
    check(ref_a, 16'h0FF8);
    check(field(rx_p, 16), 16'h1234);
    check(field(rx_s, 16), 16'hFFFE);
    check(16'(oe_s[31:16]), 16'hFFFF);
  endtask : t_dual

  task automatic t_short_frame;
    run(16'hAFF8, 31);
    check(ref_b, 16'h0000);
    run(16'hAFF8, 32);
    check(ref_b, 16'h0FF8);
  endtask : t_short_frame

  // single mode: fifo filled, refused, drained and then repeating
  task automatic t_single;
    int j;
    run(16'h8640, 32);
    check(cfg, 16'h0640);
    for (int i = 0; i < 4; i++)
      push(tab_a[i], tab_b[i]);
    check({15'h0, sample_ready}, 16'h0000);
    push(18'h00000, 18'h00000);
    for (int i = 0; i < 5; i++) begin
      run((i == 0) ? 16'h9123 : 16'h0123, (i == 0) ? 47 : 48);
      j = (i < 4) ? i : 3;
      check(field(rx_p, 16), exp_a[j]);
      check(field(rx_p, 32), exp_b[j]);
      check({15'h0, |oe_s}, 16'h0000);
      check(ref_a, 16'h0FF8);
    end
    check({15'h0, sample_ready}, 16'h0001);
    run(16'h9123, 48);
    check(ref_a, 16'h0123);
    // short-frame bit set: the 16-bit member keeps long-frame timing
    run(16'h8C40, 48);
    check(cfg, 16'h0C40);
    run(16'h9456, 47);
    check(ref_a, 16'h0123);
    check(field(rx_p, 16), exp_a[3]);
  endtask : t_single

  initial begin
    n_fail       = 0;
    comparisons  = 0;
    i_rst        = 1'b1;
    sample       = '0;
    sample_valid = 1'b0;
    repeat (5) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    tick(3);
    t_reset();
    t_dual();
    t_short_frame();
    t_single();
    test_done();
  end

  // hang guard, well above the longest expected run
  initial begin
    repeat (100000) @(posedge i_clock);
    n_fail++;
    test_done();
  end
endmodule : dasfc_ctrl_tb_top
